// ===== design/urs_consts.svh
// Register offsets, field positions and reset values of the receive status block
`ifndef URS_CONSTS_SVH
`define URS_CONSTS_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define URS_ADDR_W 12
`define URS_ALIAS_MASK 12'h008
`define URS_OFF_DATA 12'hf40
`define URS_OFF_LSTAT 12'hf41
`define URS_OFF_FSTAT 12'hf44
`define URS_OFF_IRQ_STAT 12'hf45
`define URS_OFF_IRQ_MASK 12'hf46

// ----------------------------------------------------------------
// Line status fields
// ----------------------------------------------------------------
`define URS_LS_AVAIL 7
`define URS_LS_PARITY 6
`define URS_LS_OVERRUN 5
`define URS_LS_FRAMING 4
`define URS_LS_BREAK 3
`define URS_LS_TXEMPTY 2
`define URS_LS_TXIDLE 1
`define URS_LS_CTS 0

// ----------------------------------------------------------------
// Frame status fields
// ----------------------------------------------------------------
`define URS_FS_FIRST 1
`define URS_FS_MPBIT 0
`define URS_FS_RST 8'h00

// ----------------------------------------------------------------
// Interrupt status and mask fields
// ----------------------------------------------------------------
`define URS_IRQ_W 5
`define URS_IRQ_AVAIL 0
`define URS_IRQ_BREAK 1
`define URS_IRQ_OVERRUN 2
`define URS_IRQ_FRAMING 3
`define URS_IRQ_TXEMPTY 4
`define URS_IRQ_RST 5'h00

`endif

// ===== design/urs_pkg.sv
// Shared types of the receive status block
`include "urs_consts.svh"

package urs_pkg;
    typedef logic [7:0] urs_byte_t;
    typedef logic [`URS_ADDR_W-1:0] urs_addr_t;
    typedef logic [`URS_IRQ_W-1:0] urs_irq_t;
endpackage

// ===== design/urs_sync2.sv
// Two flip-flop synchroniser for pin inputs
module urs_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Asynchronous level in, synchronised level out
    input wire logic async_in,
    output logic sync_out
);
    logic meta;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            meta <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// ===== design/urs_tx_track.sv
// Transmit holding and idle tracking, plus the byte hand-off to the transmitter
module urs_tx_track (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Write of the transmit byte register
    input wire logic data_wr,
    input wire urs_pkg::urs_byte_t wdata,
    // Transmitter progress
    input wire logic tx_first_bit_sent,
    input wire logic tx_shift_busy,
    // Hand-off to the transmitter
    output logic tx_load,
    output urs_pkg::urs_byte_t tx_byte,
    // Status
    output logic tx_holding_empty,
    output logic tx_idle
);
    // ----------------------------------------------------------------
    // Byte hand-off
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tx_load <= 1'b0;
            tx_byte <= '0;
        end else begin
            tx_load <= data_wr;
            if (data_wr) begin
                tx_byte <= wdata;
            end
        end
    end

    // ----------------------------------------------------------------
    // Holding register empty: set wins so a release is never lost
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tx_holding_empty <= 1'b1;
        end else if (tx_first_bit_sent) begin
            tx_holding_empty <= 1'b1;
        end else if (data_wr) begin
            tx_holding_empty <= 1'b0;
        end
    end

    // Idle only when nothing is shifting and nothing waits to be shifted
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            tx_idle <= 1'b1;
        end else begin
            tx_idle <= !tx_shift_busy && tx_holding_empty && !data_wr;
        end
    end
endmodule

// ===== design/urs_regs.sv
// Receive data, line status, frame status and interrupt registers of the serial port
//
// What this block does
// - Received byte shares address with transmit byte
// - Received byte register holds whole eight-bit character
// - Byte-available set on load, cleared on read except a read revealing overrun
// - Parity fault set on error, cleared on read
// - Overrun set by the read of the good byte after an unread arrival; read clears conditionally
// - Framing fault set on missing stop bit
// - Break flag set when whole character zero
// - Transmit-holding-empty set when free, write clears
// - Transmitter idle shows empty shift register
// - Clear-to-send bit reads live pin level
// - First-byte-of-frame flag set, cleared by read
// - Multidrop bit of last character, read clears
// - Overrun keeps byte, withholds overrun and break flags; overrun interrupt set on arrival
// - Holding empty after first bit shifted out
// - First byte after address match flagged
// - Interrupt on available, break, overrun, framing, transmit holding empty
`include "urs_consts.svh"

module urs_regs (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // Register port
    input wire urs_pkg::urs_addr_t reg_addr,
    input wire urs_pkg::urs_byte_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output urs_pkg::urs_byte_t reg_rdata,
    // Receiver character events
    input wire logic rx_char_done,
    input wire urs_pkg::urs_byte_t rx_char,
    input wire logic rx_ninth_bit,
    input wire logic rx_parity_err,
    input wire logic rx_stop_ok,
    input wire logic rx_mp_bit,
    input wire logic rx_first_of_frame,
    // Transmitter
    input wire logic tx_first_bit_sent,
    input wire logic tx_shift_busy,
    output logic tx_load,
    output urs_pkg::urs_byte_t tx_byte,
    // Pins
    input wire logic cts_n_pin,
    // Interrupt
    output logic irq
);
    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    // Bit 3 of the address is ignored so every register also answers 8 bytes up
    function automatic logic urs_hit(input urs_pkg::urs_addr_t a, input urs_pkg::urs_addr_t off);
        return (a & ~`URS_ALIAS_MASK) == off;
    endfunction

    logic data_rd;
    logic data_wr;
    logic mask_wr;
    logic stat_wr;
    logic lstat_rd;
    logic fstat_rd;

    assign data_rd = reg_rd && urs_hit(reg_addr, `URS_OFF_DATA);
    assign data_wr = reg_wr && urs_hit(reg_addr, `URS_OFF_DATA);
    assign mask_wr = reg_wr && urs_hit(reg_addr, `URS_OFF_IRQ_MASK);
    assign stat_wr = reg_wr && urs_hit(reg_addr, `URS_OFF_IRQ_STAT);
    assign lstat_rd = reg_rd && urs_hit(reg_addr, `URS_OFF_LSTAT);
    assign fstat_rd = reg_rd && urs_hit(reg_addr, `URS_OFF_FSTAT);
    // Writes to the frame status address are ignored; reserved bits are
    // expected to be written as zero

    // ----------------------------------------------------------------
    // Pin synchroniser and transmit tracking
    // ----------------------------------------------------------------
    logic cts_n_sync;
    logic tx_holding_empty;
    logic tx_idle;

    urs_sync2 #(
        .RST_VAL(1'b1)
    ) u_cts_sync (
        .ref_clk(ref_clk),
        .srst(srst),
        .async_in(cts_n_pin),
        .sync_out(cts_n_sync)
    );

    urs_tx_track u_tx (
        .ref_clk(ref_clk),
        .srst(srst),
        .data_wr(data_wr),
        .wdata(reg_wdata),
        .tx_first_bit_sent(tx_first_bit_sent),
        .tx_shift_busy(tx_shift_busy),
        .tx_load(tx_load),
        .tx_byte(tx_byte),
        .tx_holding_empty(tx_holding_empty),
        .tx_idle(tx_idle)
    );

    // ----------------------------------------------------------------
    // Character classification
    // ----------------------------------------------------------------
    logic rx_byte_available;
    logic char_break;
    logic load_now;
    logic ovr_now;

    assign char_break = (rx_char == '0) && !rx_ninth_bit && !rx_stop_ok;
    // A read in the same cycle frees the buffer, so the new character wins
    assign load_now = rx_char_done && (!rx_byte_available || data_rd);
    assign ovr_now = rx_char_done && rx_byte_available && !data_rd;

    // ----------------------------------------------------------------
    // Received byte buffer
    // ----------------------------------------------------------------
    urs_pkg::urs_byte_t received_byte_buffer;

    // Contents after reset carry no meaning; cleared only for tidiness
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            received_byte_buffer <= '0;
        end else if (load_now) begin
            received_byte_buffer <= rx_char;
        end
    end

    // ----------------------------------------------------------------
    // Overrun pending: kept hidden until the good byte has been read
    // ----------------------------------------------------------------
    logic ovr_pend;
    logic brk_pend;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            ovr_pend <= 1'b0;
            brk_pend <= 1'b0;
        end else if (ovr_now) begin
            ovr_pend <= 1'b1;
            brk_pend <= brk_pend || char_break;
        end else if (data_rd) begin
            ovr_pend <= 1'b0;
            brk_pend <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Line status flags
    // ----------------------------------------------------------------
    logic parity_fault;
    logic overrun_fault;
    logic framing_fault;
    logic break_seen;
    logic show_ovr;

    // Read of the good byte that reveals a hidden overrun
    assign show_ovr = data_rd && ovr_pend;

    // After a revealed overrun the flag stays up, so software knows the byte is suspect
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rx_byte_available <= 1'b0;
        end else if (load_now || show_ovr) begin
            rx_byte_available <= 1'b1;
        end else if (data_rd) begin
            rx_byte_available <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            parity_fault <= 1'b0;
        end else if (load_now) begin
            parity_fault <= rx_parity_err;
        end else if (data_rd) begin
            parity_fault <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            framing_fault <= 1'b0;
        end else if (load_now) begin
            framing_fault <= !rx_stop_ok;
        end else if (data_rd) begin
            framing_fault <= 1'b0;
        end
    end

    // Every read that does not reveal a hidden overrun clears it, even when a new character loads in the same cycle
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            overrun_fault <= 1'b0;
        end else if (load_now) begin
            overrun_fault <= show_ovr;
        end else if (show_ovr) begin
            overrun_fault <= 1'b1;
        end else if (data_rd) begin
            overrun_fault <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            break_seen <= 1'b0;
        end else if (load_now) begin
            break_seen <= char_break || (show_ovr && brk_pend);
        end else if (show_ovr) begin
            break_seen <= brk_pend;
        end else if (data_rd) begin
            break_seen <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Frame status flags
    // ----------------------------------------------------------------
    logic first_byte_of_frame;
    logic last_multidrop_bit;

    // Address compare outside flags the first data byte after a match
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            first_byte_of_frame <= 1'(`URS_FS_RST >> `URS_FS_FIRST);
        end else if (load_now) begin
            first_byte_of_frame <= rx_first_of_frame;
        end else if (data_rd) begin
            first_byte_of_frame <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            last_multidrop_bit <= 1'b0;
        end else if (load_now) begin
            last_multidrop_bit <= rx_mp_bit;
        end else if (data_rd) begin
            last_multidrop_bit <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Interrupt status, mask and output
    // ----------------------------------------------------------------
    urs_pkg::urs_irq_t irq_status;
    urs_pkg::urs_irq_t irq_mask;
    urs_pkg::urs_irq_t irq_event;

    always_comb begin
        irq_event = '0;
        irq_event[`URS_IRQ_AVAIL] = load_now || show_ovr;
        irq_event[`URS_IRQ_BREAK] = (load_now && char_break) || (show_ovr && brk_pend);
        irq_event[`URS_IRQ_OVERRUN] = ovr_now;
        irq_event[`URS_IRQ_FRAMING] = load_now && !rx_stop_ok;
        irq_event[`URS_IRQ_TXEMPTY] = tx_first_bit_sent;
    end

    // Write-one-to-clear; an event in the clearing cycle keeps its bit set
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_status <= `URS_IRQ_RST;
        end else if (stat_wr) begin
            irq_status <= (irq_status & ~reg_wdata[`URS_IRQ_W-1:0]) | irq_event;
        end else begin
            irq_status <= irq_status | irq_event;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq_mask <= `URS_IRQ_RST;
        end else if (mask_wr) begin
            irq_mask <= reg_wdata[`URS_IRQ_W-1:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_status & irq_mask);
        end
    end

    // ----------------------------------------------------------------
    // Read data
    // ----------------------------------------------------------------
    urs_pkg::urs_byte_t line_status_flags;
    urs_pkg::urs_byte_t frame_status_flags;
    urs_pkg::urs_byte_t next_rdata;

    // The clear-to-send bit is the live pin, not a latched copy
    always_comb begin
        line_status_flags = '0;
        line_status_flags[`URS_LS_AVAIL] = rx_byte_available;
        line_status_flags[`URS_LS_PARITY] = parity_fault;
        line_status_flags[`URS_LS_OVERRUN] = overrun_fault;
        line_status_flags[`URS_LS_FRAMING] = framing_fault;
        line_status_flags[`URS_LS_BREAK] = break_seen;
        line_status_flags[`URS_LS_TXEMPTY] = tx_holding_empty;
        line_status_flags[`URS_LS_TXIDLE] = tx_idle;
        line_status_flags[`URS_LS_CTS] = cts_n_sync;
        frame_status_flags = `URS_FS_RST;
        frame_status_flags[`URS_FS_FIRST] = first_byte_of_frame;
        frame_status_flags[`URS_FS_MPBIT] = last_multidrop_bit;
    end

    // Status reads only select data, they touch no flag
    always_comb begin
        next_rdata = '0;
        if (urs_hit(reg_addr, `URS_OFF_DATA)) begin
            next_rdata = received_byte_buffer;
        end else if (urs_hit(reg_addr, `URS_OFF_LSTAT)) begin
            next_rdata = line_status_flags;
        end else if (urs_hit(reg_addr, `URS_OFF_FSTAT)) begin
            next_rdata = frame_status_flags;
        end else if (urs_hit(reg_addr, `URS_OFF_IRQ_STAT)) begin
            next_rdata = {3'h0, irq_status};
        end else if (urs_hit(reg_addr, `URS_OFF_IRQ_MASK)) begin
            next_rdata = {3'h0, irq_mask};
        end
    end

    // Data stand for exactly the cycle after the read strobe
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            reg_rdata <= next_rdata;
        end else begin
            reg_rdata <= '0;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (srst);

    data_read_a: assert property (data_rd |=> reg_rdata == $past(received_byte_buffer))
        else $error("Data read returned wrong byte");
    byte_load_a: assert property (rx_char_done && !rx_byte_available
        |=> rx_byte_available && received_byte_buffer == $past(rx_char))
        else $error("Received byte not loaded");
    avail_clear_a: assert property (data_rd && !ovr_pend && !rx_char_done
        |=> !rx_byte_available ##1 !rx_byte_available || $past(rx_char_done))
        else $error("Byte available not cleared by read");
    parity_flag_a: assert property (load_now |=> parity_fault == $past(rx_parity_err))
        else $error("Parity flag mismatch");
    overrun_show_a: assert property (show_ovr && !rx_char_done
        |=> overrun_fault && rx_byte_available)
        else $error("Overrun not shown after read");
    framing_flag_a: assert property (load_now && !rx_stop_ok |=> framing_fault)
        else $error("Framing flag not set");
    break_flag_a: assert property (load_now && char_break |=> break_seen)
        else $error("Break flag not set");
    holding_clear_a: assert property (data_wr && !tx_first_bit_sent |=> !tx_holding_empty ##1 tx_load == 1'b0)
        else $error("Holding empty not cleared by write");
    idle_busy_a: assert property (tx_shift_busy |=> !tx_idle)
        else $error("Idle shown while shifting");
    cts_live_a: assert property (lstat_rd |=> reg_rdata[`URS_LS_CTS] == $past(cts_n_sync))
        else $error("Clear-to-send bit not live");
    frame_first_a: assert property (load_now && rx_first_of_frame |=> first_byte_of_frame)
        else $error("First byte of frame not flagged");
    mp_bit_a: assert property (data_rd && !rx_char_done |=> !last_multidrop_bit && !first_byte_of_frame)
        else $error("Frame status not cleared by read");
    overrun_hold_a: assert property (ovr_now && !overrun_fault
        |=> $stable(received_byte_buffer) && !overrun_fault && $stable(break_seen))
        else $error("Overrun overwrote byte or showed early");
    tx_release_a: assert property (tx_first_bit_sent |=> tx_holding_empty)
        else $error("Holding empty not set after first bit");
    status_read_a: assert property ((lstat_rd || fstat_rd) && !rx_char_done && !reg_wr
        |=> $stable(rx_byte_available) && $stable(overrun_fault) && $stable(break_seen))
        else $error("Status read changed a flag");
    irq_out_a: assert property (|(irq_status & irq_mask) |=> irq)
        else $error("Interrupt not raised");

    cover property (ovr_now ##[1:50] show_ovr);
    cover property (load_now && char_break);
    cover property (data_wr ##[1:100] tx_first_bit_sent);
    cover property ($rose(irq));
endmodule

// ===== dv/urs_far_end.sv
// Behavioural model of the line side: receiver character events and transmitter progress
module urs_far_end (
    // Clock
    input wire logic ref_clk,
    // Transmit hand-off from the block
    input wire logic tx_load,
    input wire urs_pkg::urs_byte_t tx_byte,
    // Receiver character events
    output logic rx_char_done,
    output urs_pkg::urs_byte_t rx_char,
    output logic rx_ninth_bit,
    output logic rx_parity_err,
    output logic rx_stop_ok,
    output logic rx_mp_bit,
    output logic rx_first_of_frame,
    // Transmitter progress
    output logic tx_first_bit_sent,
    output logic tx_shift_busy
);
    timeunit 1ns;
    timeprecision 1ps;
    urs_pkg::urs_byte_t sent_byte = 8'h00;
    initial begin
        {rx_char_done, rx_ninth_bit, rx_parity_err, rx_stop_ok, rx_mp_bit, rx_first_of_frame} = 6'h00;
        rx_char = 8'h00;
        tx_first_bit_sent = 1'b0;
        tx_shift_busy = 1'b0;
    end
    // One character; q is {ninth, parity error, stop ok, multidrop, first of frame}.
    // Qualifiers are inverted afterwards so nothing can lean on stale values.
    task automatic send(input urs_pkg::urs_byte_t d, input logic [4:0] q);
        @(posedge ref_clk);
        rx_char_done <= 1'b1;
        rx_char <= d;
        {rx_ninth_bit, rx_parity_err, rx_stop_ok, rx_mp_bit, rx_first_of_frame} <= q;
        @(posedge ref_clk);
        rx_char_done <= 1'b0;
        rx_char <= ~d;
        {rx_ninth_bit, rx_parity_err, rx_stop_ok, rx_mp_bit, rx_first_of_frame} <= ~q;
    endtask
    // Shifter: first bit out 4 cycles after load, character finished 15 cycles after load
    always begin
        @(posedge ref_clk);
        if (tx_load === 1'b1) begin
            sent_byte <= tx_byte;
            tx_shift_busy <= 1'b1;
            repeat (4) @(posedge ref_clk);
            tx_first_bit_sent <= 1'b1;
            @(posedge ref_clk);
            tx_first_bit_sent <= 1'b0;
            repeat (10) @(posedge ref_clk);
            tx_shift_busy <= 1'b0;
        end
    end
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the receive data and status registers
`include "urs_consts.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam urs_pkg::urs_addr_t dat = `URS_OFF_DATA;
    localparam urs_pkg::urs_addr_t lstat = `URS_OFF_LSTAT;
    localparam urs_pkg::urs_addr_t fstat = `URS_OFF_FSTAT;
    localparam urs_pkg::urs_addr_t ist = `URS_OFF_IRQ_STAT;
    localparam urs_pkg::urs_addr_t imk = `URS_OFF_IRQ_MASK;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    urs_pkg::urs_addr_t reg_addr = 12'h000;
    urs_pkg::urs_byte_t reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic cts_n_pin = 1'b1;
    urs_pkg::urs_byte_t reg_rdata, rx_char, tx_byte;
    logic rx_char_done, rx_ninth_bit, rx_parity_err, rx_stop_ok, rx_mp_bit, rx_first_of_frame;
    logic tx_first_bit_sent, tx_shift_busy, tx_load, irq;
    int n_fail = 0;
    int comparisons = 0;
    always #2.5 ref_clk = ~ref_clk;
    urs_regs DUT (.ref_clk(ref_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_char_done(rx_char_done),
        .rx_char(rx_char), .rx_ninth_bit(rx_ninth_bit), .rx_parity_err(rx_parity_err),
        .rx_stop_ok(rx_stop_ok), .rx_mp_bit(rx_mp_bit), .rx_first_of_frame(rx_first_of_frame),
        .tx_first_bit_sent(tx_first_bit_sent), .tx_shift_busy(tx_shift_busy), .tx_load(tx_load),
        .tx_byte(tx_byte), .cts_n_pin(cts_n_pin), .irq(irq));
    urs_far_end far (.ref_clk(ref_clk), .tx_load(tx_load), .tx_byte(tx_byte),
        .rx_char_done(rx_char_done), .rx_char(rx_char), .rx_ninth_bit(rx_ninth_bit),
        .rx_parity_err(rx_parity_err), .rx_stop_ok(rx_stop_ok), .rx_mp_bit(rx_mp_bit),
        .rx_first_of_frame(rx_first_of_frame), .tx_first_bit_sent(tx_first_bit_sent),
        .tx_shift_busy(tx_shift_busy));

    // ----------------------------------------
    // Bus tasks and checking
    // ----------------------------------------
    task automatic chk(input urs_pkg::urs_byte_t got, input urs_pkg::urs_byte_t exp, input string what);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input urs_pkg::urs_addr_t a, input urs_pkg::urs_byte_t d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample just past that edge
    task automatic rd(input urs_pkg::urs_addr_t a, input urs_pkg::urs_byte_t exp, input string what);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp, what);
    endtask
    task automatic settle();
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        rd(lstat, 8'h07, "line status at reset");
        rd(fstat, 8'h00, "frame status at reset");
        rd(12'hf43, 8'h00, "unmapped read");
        wr(lstat, 8'hff);
        rd(lstat, 8'h07, "line status after write");
        wr(fstat, 8'h03);
        rd(fstat, 8'h00, "frame status write ignored");
        $display("test reset done");
        far.send(8'ha5, 5'b11011);
        rd(lstat, 8'hd7, "parity and framing");
        rd(lstat, 8'hd7, "second status read");
        rd(fstat, 8'h03, "frame status");
        rd(dat | `URS_ALIAS_MASK, 8'ha5, "byte via alias");
        rd(lstat, 8'h07, "flags after data read");
        rd(fstat, 8'h00, "frame after data read");
        far.send(8'h00, 5'b00000);
        rd(lstat, 8'h9f, "break");
        rd(dat, 8'h00, "break byte");
        $display("test receive done");
        wr(dat, 8'h5a);
        rd(lstat, 8'h01, "transmit busy");
        repeat (6) @(posedge ref_clk);
        chk(far.sent_byte, 8'h5a, "byte handed to shifter");
        rd(lstat, 8'h05, "holding empty after first bit");
        repeat (12) @(posedge ref_clk);
        rd(lstat, 8'h07, "transmitter idle");
        @(posedge ref_clk);
        cts_n_pin <= 1'b0;
        settle();
        rd(lstat, 8'h06, "clear-to-send low");
        @(posedge ref_clk);
        cts_n_pin <= 1'b1;
        settle();
        $display("test transmit done");
        rd(ist, 8'h1b, "events so far");
        wr(ist, 8'h1f);
        rd(ist, 8'h00, "interrupt status cleared");
        wr(imk, 8'h01);
        rd(imk, 8'h01, "mask readback");
        far.send(8'h11, 5'b00100);
        settle();
        chk({7'h00, irq}, 8'h01, "interrupt raised");
        rd(dat, 8'h11, "byte read");
        wr(ist, 8'h01);
        settle();
        chk({7'h00, irq}, 8'h00, "interrupt cleared");
        wr(imk, 8'h00);
        far.send(8'h00, 5'b00000);
        settle();
        chk({7'h00, irq}, 8'h00, "interrupt masked");
        rd(ist, 8'h0b, "masked events");
        rd(dat, 8'h00, "break byte read");
        wr(ist, 8'h1f);
        $display("test interrupt done");
        far.send(8'h3c, 5'b00100);
        far.send(8'h55, 5'b00100);
        rd(lstat, 8'h87, "overrun withheld");
        rd(dat, 8'h3c, "valid byte kept");
        rd(lstat, 8'ha7, "overrun revealed");
        rd(ist, 8'h05, "overrun event");
        rd(dat, 8'h3c, "byte not replaced");
        rd(lstat, 8'h07, "overrun cleared");
        $display("test overrun done");
        wrap_up();
    end
    // Whole run is under 150 cycles; this margin only catches a hang
    initial begin
        repeat (3000) @(posedge ref_clk);
        n_fail++;
        wrap_up();
    end
endmodule
